/* src/lss_cfg.svh */
// timing and geometry constants for the linear sensor scan link
// assumes mclk at 250 MHz on both ends; included by bare name
`ifndef LSS_CFG_SVH
`define LSS_CFG_SVH

// =====================================================================
// clock rates
`define LSS_MCLK_KHZ 250000
`define LSS_PIX_FMAX_KHZ 10000
// least half period of the pixel clock in mclk cycles, rounded up
`define LSS_PIX_HALF ((`LSS_MCLK_KHZ + 2 * `LSS_PIX_FMAX_KHZ - 1) / (2 * `LSS_PIX_FMAX_KHZ))

// =====================================================================
// scan timing in pixel-clock periods
`define LSS_HI_MIN 6
`define LSS_LO_MIN 100
`define LSS_PERIOD_MIN 4188
`define LSS_INTEG_EXTRA 48
`define LSS_FIRST_PIX_STROBE 89
// pixel clock duty limits in percent
`define LSS_DUTY_MIN 45
`define LSS_DUTY_MAX 55

// =====================================================================
// geometry and widths
`define LSS_NUM_PIX 4096
`define LSS_VIDEO_W 12
`define LSS_CNT_W 16

`endif

/* src/lss_ctrl.sv */
// controller end: makes pixel clock and scan launch, captures pixel values
// assumes the sensor end answers on the link; link inputs are asynchronous
`timescale 1ns/1ps
`include "lss_cfg.svh"

// What this block does
// - launch high at least six pixel clocks
// - launch low at least hundred pixel clocks
// - sensor shifts on first rise after fall
// - integration equals high phase plus 48
// - exposure set by launch high length
// - first pixel at strobe number 89
// - capture pixel on rising strobe edge
// - discard whole first scan after power-up
// - link outputs always at defined levels
// - pixel clock duty between 45 and 55
// - one pixel per clock, 10 MHz max
// - full readout needs 4188 clock scan period
// - keep period and high phase short
module lss_ctrl #(
  parameter int NUM_PIX = `LSS_NUM_PIX,
  parameter int VW = `LSS_VIDEO_W,
  parameter int PIX_HALF = `LSS_PIX_HALF
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, active low
  lss_if.ctrl lnk, // link to sensor
  input wire logic run, // keep scanning while high
  input wire logic [`LSS_CNT_W-1:0] hi_len, // launch high, pixel clocks
  input wire logic [`LSS_CNT_W-1:0] period_len, // scan period, pixel clocks
  output logic [`LSS_CNT_W-1:0] integ_cycles, // exposure of current scan
  output logic pix_valid, // one-cycle pulse per valid pixel
  output logic [VW-1:0] pix_data, // captured pixel value
  output logic [`LSS_CNT_W-1:0] pix_index, // index of captured pixel
  output logic scan_end, // one-cycle pulse at end of scan
  output logic data_ok // first scan is over
);
  localparam int CW = `LSS_CNT_W;
  localparam logic [CW-1:0] HALF = CW'(PIX_HALF);
  localparam logic [CW-1:0] HI_MIN = CW'(`LSS_HI_MIN);
  localparam logic [CW-1:0] LO_MIN = CW'(`LSS_LO_MIN);
  localparam logic [CW-1:0] PER_MIN = CW'(`LSS_PERIOD_MIN);
  localparam logic [CW-1:0] EXTRA = CW'(`LSS_INTEG_EXTRA);
  localparam logic [CW-1:0] FIRST_STB = CW'(`LSS_FIRST_PIX_STROBE);
  localparam logic [CW-1:0] NPIX = CW'(NUM_PIX);

  function automatic logic [CW-1:0] at_least(input logic [CW-1:0] v, input logic [CW-1:0] lo);
    at_least = (v < lo) ? lo : v;
  endfunction : at_least

  // =====================================================================
  // pixel clock divider, equal halves
  logic [CW-1:0] div_ff, nxt_div;
  logic pclk_ff, nxt_pclk, pclk_fall;

  always_comb begin
    nxt_div = div_ff + CW'(1);
    nxt_pclk = pclk_ff;
    if (div_ff == HALF - CW'(1)) begin
      nxt_div = '0;
      nxt_pclk = ~pclk_ff;
    end
  end
  assign pclk_fall = (div_ff == HALF - CW'(1)) && pclk_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= '0;
      pclk_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      pclk_ff <= nxt_pclk;
    end
  end

  // =====================================================================
  // scan launch scheduler, steps on pixel clock falls
  lss_pkg::lss_ctl_state_t fsm_ff, nxt_fsm;
  logic [CW-1:0] cnt_ff, nxt_cnt, hi_ff, nxt_hi, per_ff, nxt_per, integ_ff, nxt_integ;
  logic launch_ff, nxt_launch;
  logic [CW-1:0] hi_req, per_req;

  always_comb begin
    nxt_fsm = fsm_ff;
    nxt_cnt = cnt_ff;
    nxt_hi = hi_ff;
    nxt_per = per_ff;
    nxt_integ = integ_ff;
    nxt_launch = launch_ff;
    hi_req = at_least(hi_len, HI_MIN);
    // requested period, raised to the shortest that still reads every pixel and keeps the low phase
    per_req = at_least(at_least(period_len, hi_req + LO_MIN), PER_MIN);
    if (pclk_fall) begin
      case (fsm_ff)
        lss_pkg::LSS_CTL_IDLE: begin
          if (run) begin
            nxt_fsm = lss_pkg::LSS_CTL_HIGH;
            nxt_cnt = CW'(1);
            nxt_hi = hi_req;
            nxt_per = per_req;
            nxt_integ = hi_req + EXTRA;
            nxt_launch = 1'b1;
          end
        end
        lss_pkg::LSS_CTL_HIGH: begin
          nxt_cnt = cnt_ff + CW'(1);
          if (cnt_ff == hi_ff) begin
            nxt_fsm = lss_pkg::LSS_CTL_LOW;
            nxt_launch = 1'b0;
          end
        end
        lss_pkg::LSS_CTL_LOW: begin
          nxt_cnt = cnt_ff + CW'(1);
          if (cnt_ff == per_ff) begin
            nxt_cnt = CW'(1);
            if (run) begin
              nxt_fsm = lss_pkg::LSS_CTL_HIGH;
              nxt_hi = hi_req;
              nxt_per = per_req;
              nxt_integ = hi_req + EXTRA;
              nxt_launch = 1'b1;
            end else begin
              nxt_fsm = lss_pkg::LSS_CTL_IDLE;
            end
          end
        end
        default: begin
          nxt_fsm = lss_pkg::LSS_CTL_IDLE;
          nxt_launch = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fsm_ff <= lss_pkg::LSS_CTL_IDLE;
      cnt_ff <= '0;
      hi_ff <= HI_MIN;
      per_ff <= PER_MIN;
      integ_ff <= '0;
      launch_ff <= 1'b0;
    end else begin
      fsm_ff <= nxt_fsm;
      cnt_ff <= nxt_cnt;
      hi_ff <= nxt_hi;
      per_ff <= nxt_per;
      integ_ff <= nxt_integ;
      launch_ff <= nxt_launch;
    end
  end

  // =====================================================================
  // link input synchronisers
  logic stb_s1_ff, stb_s2_ff, stb_d_ff, done_s1_ff, done_s2_ff, done_d_ff;
  logic [VW-1:0] vid_s1_ff, vid_s2_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stb_s1_ff <= 1'b0;
      stb_s2_ff <= 1'b0;
      stb_d_ff <= 1'b0;
      done_s1_ff <= 1'b0;
      done_s2_ff <= 1'b0;
      done_d_ff <= 1'b0;
      vid_s1_ff <= '0;
      vid_s2_ff <= '0;
    end else begin
      stb_s1_ff <= lnk.sample_strobe;
      stb_s2_ff <= stb_s1_ff;
      stb_d_ff <= stb_s2_ff;
      done_s1_ff <= lnk.scan_done_flag;
      done_s2_ff <= done_s1_ff;
      done_d_ff <= done_s2_ff;
      vid_s1_ff <= lnk.video;
      vid_s2_ff <= vid_s1_ff;
    end
  end

  // =====================================================================
  // pixel capture
  logic [CW-1:0] stb_cnt_ff, nxt_stb_cnt, idx_ff, nxt_idx, stb_next;
  logic valid_ff, nxt_valid, end_ff, nxt_end, ok_ff, nxt_ok;
  logic [VW-1:0] data_ff, nxt_data;
  logic launch_drop;

  // video is stable half a pixel clock before the strobe rises, so the
  // synchronised copy is safe to take at the synchronised strobe edge
  assign launch_drop = (nxt_fsm == lss_pkg::LSS_CTL_LOW) && (fsm_ff == lss_pkg::LSS_CTL_HIGH);
  assign stb_next = stb_cnt_ff + CW'(1);

  always_comb begin
    nxt_stb_cnt = stb_cnt_ff;
    nxt_idx = idx_ff;
    nxt_valid = 1'b0;
    nxt_end = 1'b0;
    nxt_ok = ok_ff;
    nxt_data = data_ff;
    if (launch_drop) begin
      nxt_stb_cnt = '0;
    end else if (stb_s2_ff && !stb_d_ff) begin
      nxt_stb_cnt = stb_next;
      if (stb_next >= FIRST_STB && stb_next - FIRST_STB < NPIX) begin
        nxt_idx = stb_next - FIRST_STB;
        nxt_data = vid_s2_ff;
        nxt_valid = ok_ff;
      end
    end
    if (done_s2_ff && !done_d_ff) begin
      nxt_end = 1'b1;
      nxt_ok = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stb_cnt_ff <= '0;
      idx_ff <= '0;
      valid_ff <= 1'b0;
      end_ff <= 1'b0;
      ok_ff <= 1'b0;
      data_ff <= '0;
    end else begin
      stb_cnt_ff <= nxt_stb_cnt;
      idx_ff <= nxt_idx;
      valid_ff <= nxt_valid;
      end_ff <= nxt_end;
      ok_ff <= nxt_ok;
      data_ff <= nxt_data;
    end
  end

  assign lnk.pix_clk = pclk_ff;
  assign lnk.scan_launch_pulse = launch_ff;
  assign integ_cycles = integ_ff;
  assign pix_valid = valid_ff;
  assign pix_data = data_ff;
  assign pix_index = idx_ff;
  assign scan_end = end_ff;
  assign data_ok = ok_ff;
endmodule : lss_ctrl

/* src/lss_if.sv */
// wires between the scan controller and the sensor timing end
// assumes both ends run on their own mclk; no clock travels here but pix_clk
`timescale 1ns/1ps
`include "lss_cfg.svh"

interface lss_if #(
  parameter int VW = `LSS_VIDEO_W
);
  logic pix_clk; // pixel clock from controller
  logic scan_launch_pulse; // scan launch from controller
  logic sample_strobe; // capture strobe from sensor
  logic [VW-1:0] video; // pixel value from sensor
  logic scan_done_flag; // end of scan from sensor

  modport sensor (
    input pix_clk,
    input scan_launch_pulse,
    output sample_strobe,
    output video,
    output scan_done_flag
  );

  modport ctrl (
    output pix_clk,
    output scan_launch_pulse,
    input sample_strobe,
    input video,
    input scan_done_flag
  );
endinterface : lss_if

/* src/lss_pkg.sv */
// state types shared by both ends of the linear sensor scan link
// assumes nothing beyond a SystemVerilog compiler
package lss_pkg;

  typedef enum logic {LSS_SNS_IDLE, LSS_SNS_SHIFT} lss_sns_state_t;

  typedef enum logic [1:0] {LSS_CTL_IDLE, LSS_CTL_HIGH, LSS_CTL_LOW} lss_ctl_state_t;

endpackage : lss_pkg

/* src/lss_sensor.sv */
// sensor end: readout timing generator driven by pixel clock and scan launch
// assumes link inputs are asynchronous to mclk and pixel clock well below mclk/4
`timescale 1ns/1ps
`include "lss_cfg.svh"

module lss_sensor #(
  parameter int NUM_PIX = `LSS_NUM_PIX,
  parameter int VW = `LSS_VIDEO_W
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, active low
  lss_if.sensor lnk, // link to controller
  input wire logic [VW-1:0] light_level, // value presented for every pixel after the first scan (first scan shows all ones)
  output logic [`LSS_CNT_W-1:0] integ_len, // last integration, pixel clocks
  output logic scanning // readout in progress
);
  localparam int CW = `LSS_CNT_W;
  localparam logic [CW-1:0] FIRST_STB = CW'(`LSS_FIRST_PIX_STROBE);
  localparam logic [CW-1:0] LAST_STB = CW'(`LSS_FIRST_PIX_STROBE - 1 + NUM_PIX);
  localparam logic [CW-1:0] EXTRA = CW'(`LSS_INTEG_EXTRA);

  // =====================================================================
  // input synchronisers
  logic clk_s1_ff, clk_s2_ff, clk_d_ff, lp_s1_ff, lp_s2_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_d_ff <= 1'b0;
      lp_s1_ff <= 1'b0;
      lp_s2_ff <= 1'b0;
    end else begin
      clk_s1_ff <= lnk.pix_clk;
      clk_s2_ff <= clk_s1_ff;
      clk_d_ff <= clk_s2_ff;
      lp_s1_ff <= lnk.scan_launch_pulse;
      lp_s2_ff <= lp_s1_ff;
    end
  end

  logic pclk_rise, pclk_fall;
  assign pclk_rise = clk_s2_ff & ~clk_d_ff;
  assign pclk_fall = ~clk_s2_ff & clk_d_ff;

  // =====================================================================
  // readout sequencer
  lss_pkg::lss_sns_state_t state_ff, nxt_state;
  logic lp_prev_ff, nxt_lp_prev, scanning_ff, nxt_scanning;
  logic [CW-1:0] hi_cnt_ff, nxt_hi_cnt, stb_cnt_ff, nxt_stb_cnt, integ_ff, nxt_integ;
  logic strobe_ff, nxt_strobe, done_ff, nxt_done, first_ff, nxt_first;
  logic [VW-1:0] video_ff, nxt_video;
  logic [CW-1:0] stb_next;

  always_comb begin
    nxt_state = state_ff;
    nxt_lp_prev = lp_prev_ff;
    nxt_hi_cnt = hi_cnt_ff;
    nxt_stb_cnt = stb_cnt_ff;
    nxt_integ = integ_ff;
    nxt_strobe = strobe_ff;
    nxt_done = done_ff;
    nxt_first = first_ff;
    nxt_video = video_ff;
    stb_next = stb_cnt_ff + CW'(1);
    if (pclk_rise) begin
      nxt_lp_prev = lp_s2_ff;
      if (lp_s2_ff) begin
        // saturate the high-phase count at all ones; the exposure report adds 48 to it and can still wrap
        if (!lp_prev_ff) begin
          nxt_hi_cnt = CW'(1);
        end else if (hi_cnt_ff != {CW{1'b1}}) begin
          nxt_hi_cnt = hi_cnt_ff + CW'(1);
        end
      end
      if (!lp_s2_ff && lp_prev_ff) begin
        nxt_state = lss_pkg::LSS_SNS_SHIFT;
        nxt_stb_cnt = CW'(1);
        nxt_strobe = 1'b1;
        nxt_integ = hi_cnt_ff + EXTRA;
      end else if (state_ff == lss_pkg::LSS_SNS_SHIFT) begin
        if (stb_cnt_ff == LAST_STB) begin
          nxt_state = lss_pkg::LSS_SNS_IDLE;
          nxt_done = 1'b1;
          nxt_first = 1'b0;
        end else begin
          nxt_stb_cnt = stb_next;
          nxt_strobe = 1'b1;
        end
      end
    end else if (pclk_fall) begin
      nxt_strobe = 1'b0;
      nxt_done = 1'b0;
      // value settles half a pixel clock ahead of the strobe that marks it
      if (state_ff == lss_pkg::LSS_SNS_SHIFT && stb_next >= FIRST_STB &&
          stb_next <= LAST_STB) begin
        nxt_video = first_ff ? {VW{1'b1}} : light_level;
      end else begin
        nxt_video = '0;
      end
    end
    nxt_scanning = (nxt_state == lss_pkg::LSS_SNS_SHIFT);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= lss_pkg::LSS_SNS_IDLE;
      lp_prev_ff <= 1'b0;
      scanning_ff <= 1'b0;
      hi_cnt_ff <= '0;
      stb_cnt_ff <= '0;
      integ_ff <= '0;
      strobe_ff <= 1'b0;
      done_ff <= 1'b0;
      first_ff <= 1'b1;
      video_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      lp_prev_ff <= nxt_lp_prev;
      scanning_ff <= nxt_scanning;
      hi_cnt_ff <= nxt_hi_cnt;
      stb_cnt_ff <= nxt_stb_cnt;
      integ_ff <= nxt_integ;
      strobe_ff <= nxt_strobe;
      done_ff <= nxt_done;
      first_ff <= nxt_first;
      video_ff <= nxt_video;
    end
  end

  assign lnk.sample_strobe = strobe_ff;
  assign lnk.video = video_ff;
  assign lnk.scan_done_flag = done_ff;
  assign integ_len = integ_ff;
  assign scanning = scanning_ff;
endmodule : lss_sensor

/* verif/linear_sensor_scan_timing_tb.sv */
// bench: controller end and sensor end joined by the link, two full scans
// assumes the src/ files and the link checker are compiled before it
`timescale 1ns/1ps
`include "lss_cfg.svh"

module linear_sensor_scan_timing_tb;
  // short pixel clock keeps two 4188-period scans near 50k mclk
  localparam int PH = 3;
  localparam int VW = `LSS_VIDEO_W;
  localparam logic [VW-1:0] LIGHT = 12'hA5C;
  logic mclk, rst_n, run, scanning, pix_valid, scan_end, data_ok;
  logic [15:0] hi_len, period_len, integ_len, integ_cycles, pix_index;
  logic [VW-1:0] light_level, pix_data;
  int err_count = 0;
  int n_tests = 0;
  logic stb_ff = 1'b0;
  logic lnch_ff = 1'b0;
  int stb_cnt = 0;
  logic [VW-1:0] v88 = '0;
  logic [VW-1:0] v89 = '0;

  lss_if #(.VW(VW)) lnk ();
  lss_sensor #(.NUM_PIX(`LSS_NUM_PIX), .VW(VW)) i_lss_sensor (.mclk(mclk), .rst_n(rst_n),
    .lnk(lnk), .light_level(light_level), .integ_len(integ_len), .scanning(scanning));
  lss_ctrl #(.NUM_PIX(`LSS_NUM_PIX), .VW(VW), .PIX_HALF(PH)) i_lss_ctrl (.mclk(mclk),
    .rst_n(rst_n), .lnk(lnk), .run(run), .hi_len(hi_len), .period_len(period_len),
    .integ_cycles(integ_cycles), .pix_valid(pix_valid), .pix_data(pix_data),
    .pix_index(pix_index), .scan_end(scan_end), .data_ok(data_ok));
  lss_properties #(.NUM_PIX(`LSS_NUM_PIX), .VW(VW), .PIX_HALF(PH)) i_lss_properties (
    .mclk(mclk), .rst_n(rst_n), .pix_clk(lnk.pix_clk),
    .scan_launch_pulse(lnk.scan_launch_pulse), .sample_strobe(lnk.sample_strobe),
    .video(lnk.video), .scan_done_flag(lnk.scan_done_flag));

  // =====================================================================
  // clock, wire monitor, checks
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // strobes since the launch fell, video seen at strobes 88 and 89
  always @(posedge mclk) begin
    stb_ff <= lnk.sample_strobe;
    lnch_ff <= lnk.scan_launch_pulse;
    if (lnch_ff && !lnk.scan_launch_pulse) begin
      stb_cnt <= 0;
    end else if (lnk.sample_strobe && !stb_ff) begin
      stb_cnt <= stb_cnt + 1;
      if (stb_cnt == 87) v88 <= lnk.video;
      if (stb_cnt == 88) v89 <= lnk.video;
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask : check

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // =====================================================================
  // scenarios
  task automatic test_reset;
    check("idle outputs", 16'({lnk.pix_clk, lnk.scan_launch_pulse, lnk.sample_strobe,
      lnk.scan_done_flag, pix_valid, scan_end, data_ok, scanning}), 16'h0000);
    $display("test reset done");
  endtask : test_reset

  // launch high asked below minimum; whole first scan must be withheld
  task automatic test_first_scan;
    int k;
    int nv;
    nv = 0;
    k = 0;
    run = 1'b1;
    while (scanning !== 1'b1 && k < 2000) begin
      @(negedge mclk);
      k++;
    end
    check("integ_cycles scan 1", integ_cycles, 16'h0036);
    hi_len = 16'h000A;
    k = 0;
    while (scan_end !== 1'b1 && k < 40000) begin
      @(negedge mclk);
      k++;
      if (pix_valid === 1'b1) nv++;
    end
    @(negedge mclk);
    check("scan 1 ended", 16'(k < 40000), 16'h0001);
    check("pixels passed in scan 1", 16'(nv), 16'h0000);
    check("data_ok", 16'(data_ok), 16'h0001);
    check("integ_len scan 1", integ_len, 16'h0036);
    check("strobes in scan 1", 16'(stb_cnt), 16'h1058);
    check("video strobe 88", 16'(v88), 16'h0000);
    check("video strobe 89", 16'(v89), 16'h0FFF);
    $display("test first_scan done");
  endtask : test_first_scan

  // longer high phase, then every pixel captured in order with its value
  task automatic test_second_scan;
    int k;
    int idx;
    k = 0;
    idx = 0;
    while (scan_end !== 1'b1 && k < 40000) begin
      @(negedge mclk);
      k++;
      if (pix_valid === 1'b1) begin
        if (idx == 0) begin
          check("integ_cycles scan 2", integ_cycles, 16'h003A);
          check("integ_len scan 2", integ_len, 16'h003A);
          run = 1'b0;
        end
        check("pix_index", pix_index, 16'(idx));
        check("pix_data", 16'(pix_data), 16'(LIGHT));
        idx++;
      end
    end
    check("pixels in scan 2", 16'(idx), 16'h1000);
    check("strobes in scan 2", 16'(stb_cnt), 16'h1058);
    check("video strobe 88", 16'(v88), 16'h0000);
    check("video strobe 89", 16'(v89), 16'(LIGHT));
    repeat (100) @(negedge mclk);
    check("launch idle after run", 16'(lnk.scan_launch_pulse), 16'h0000);
    check("no scan after run", 16'(scanning), 16'h0000);
    $display("test second_scan done");
  endtask : test_second_scan

  // two scans take about 50k mclk
  initial begin
    repeat (80000) @(posedge mclk);
    err_count++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    run = 1'b0;
    hi_len = 16'h0003;
    period_len = 16'h0000;
    light_level = LIGHT;
    repeat (4) @(negedge mclk);
    test_reset();
    rst_n = 1'b1;
    @(negedge mclk);
    test_first_scan();
    test_second_scan();
    wrap_up();
  end
endmodule : linear_sensor_scan_timing_tb

/* verif/lss_properties.sv */
// link checker: timing relations on the wires between controller and sensor ends
// assumes the bench instantiates it beside the link interface, with PIX_HALF as the controller
`timescale 1ns/1ps
`include "lss_cfg.svh"

module lss_properties #(
  parameter int NUM_PIX = `LSS_NUM_PIX,
  parameter int VW = `LSS_VIDEO_W,
  parameter int PIX_HALF = `LSS_PIX_HALF
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic pix_clk, // pixel clock
  input wire logic scan_launch_pulse, // scan launch
  input wire logic sample_strobe, // capture strobe
  input wire logic [VW-1:0] video, // pixel value
  input wire logic scan_done_flag // end of scan
);
  localparam int PER = 2 * PIX_HALF;
  localparam int R03_LO = PIX_HALF + 1;
  localparam int R03_HI = PIX_HALF + 6;
  logic pc_ff, ln_ff, stb_ff;
  logic [31:0] half_ff, hi_ff, lvl_ff, per_ff, gap_ff, stb_cnt_ff;

  // =====================================================================
  // helper counters
  // interval counters start saturated so the first edge after reset is never judged
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    return (v == '1) ? v : v + 32'h1;
  endfunction : sat_inc

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff <= 1'b0;
      ln_ff <= 1'b0;
      stb_ff <= 1'b0;
      half_ff <= '1;
      hi_ff <= '0;
      lvl_ff <= '1;
      per_ff <= '1;
      gap_ff <= '1;
      stb_cnt_ff <= '0;
    end else begin
      pc_ff <= pix_clk;
      ln_ff <= scan_launch_pulse;
      stb_ff <= sample_strobe;
      half_ff <= (pix_clk != pc_ff) ? 32'h1 : sat_inc(half_ff);
      if (pc_ff && !pix_clk) hi_ff <= half_ff;
      lvl_ff <= (scan_launch_pulse != ln_ff) ? 32'h1 : sat_inc(lvl_ff);
      per_ff <= (scan_launch_pulse && !ln_ff) ? 32'h1 : sat_inc(per_ff);
      gap_ff <= (sample_strobe && !stb_ff) ? 32'h1 : sat_inc(gap_ff);
      if (ln_ff && !scan_launch_pulse) stb_cnt_ff <= '0;
      else if (sample_strobe && !stb_ff) stb_cnt_ff <= stb_cnt_ff + 32'h1;
    end
  end

  // =====================================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  launch_high_a: assert property (
    ln_ff && !scan_launch_pulse |-> lvl_ff >= `LSS_HI_MIN * PER)
    else $error("launch high phase too short");
  launch_low_a: assert property (
    !ln_ff && scan_launch_pulse |-> lvl_ff >= `LSS_LO_MIN * PER)
    else $error("launch low phase too short");
  // exact only while the bench asks for the shortest period
  scan_period_a: assert property (
    !ln_ff && scan_launch_pulse && per_ff != '1 |-> per_ff == `LSS_PERIOD_MIN * PER)
    else $error("scan period differs from minimum");
  pix_half_a: assert property (
    pix_clk != pc_ff |-> half_ff >= PIX_HALF)
    else $error("pixel clock phase too short");
  clock_duty_a: assert property (
    pix_clk && !pc_ff && hi_ff != 0 |-> 100 * hi_ff >= `LSS_DUTY_MIN * (hi_ff + half_ff)
      && 100 * hi_ff <= `LSS_DUTY_MAX * (hi_ff + half_ff))
    else $error("pixel clock duty out of range");
  shift_start_a: assert property (
    $fell(scan_launch_pulse) |-> ##[R03_LO:R03_HI] $rose(sample_strobe))
    else $error("first strobe not on first rise after launch");
  strobe_gap_a: assert property (
    $rose(sample_strobe) && stb_cnt_ff != 0 |-> gap_ff == PER)
    else $error("strobes not one per pixel clock");
  video_hold_a: assert property (
    $rose(sample_strobe) |-> $stable(video) ##1 $stable(video))
    else $error("video moves at strobe edge");
  done_count_a: assert property (
    $rose(scan_done_flag) |-> stb_cnt_ff == NUM_PIX + `LSS_FIRST_PIX_STROBE - 1)
    else $error("scan done after wrong strobe count");
  done_alone_a: assert property (
    scan_done_flag |-> !sample_strobe)
    else $error("scan done together with strobe");
endmodule : lss_properties
